// File: verilog/ddr_pin_params.svh
// constants for the pin-level command and data interface
// assumes codes are formed as {cs_n, ras_n, cas_n, we_n}
`ifndef DDR_PIN_PARAMS_SVH
`define DDR_PIN_PARAMS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define CODE_MODE_SET 4'h0
`define CODE_REFRESH 4'h1
`define CODE_PRECHARGE 4'h2
`define CODE_ACTIVATE 4'h3
`define CODE_WRITE 4'h4
`define CODE_READ 4'h5

// ----------------------------------------
// bank_select values on mode-register writes
// ----------------------------------------
`define SEL_MODE_REG 3'h0
`define SEL_EXT_REG_ONE 3'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_PRECHARGE_ALL 10
`define BIT_STROBE_DIFF_OFF 10
`define BIT_READ_STROBE_EN 11
`define BIT_TERM_LO 2
`define BIT_TERM_HI 6
`define MR_BL_MSB 2
`define MR_BL_LSB 0
`define BL_EIGHT 3'h3
`define BEATS_FOUR 4'h4
`define BEATS_EIGHT 4'h8

// ----------------------------------------
// reset values
// ----------------------------------------
`define MR_RESET 14'h0000
`define EMR1_RESET 14'h0000

`endif

// File: verilog/ddr_pin_pkg.sv
// types shared by the pin interface and its command decoder
// assumes the constants header is included by the design files
package ddr_pin_pkg;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_MODE = 3'h1,
        CMD_REFRESH = 3'h2,
        CMD_PRECHARGE = 3'h3,
        CMD_ACTIVATE = 3'h4,
        CMD_WRITE = 3'h5,
        CMD_READ = 3'h6
    } cmd_kind_t;

    typedef enum logic [2:0] {
        PWR_IDLE = 3'h0,
        PWR_ACTIVE = 3'h1,
        PWR_PRE_DOWN = 3'h2,
        PWR_ACT_DOWN = 3'h3,
        PWR_SELF_REF = 3'h4
    } pwr_state_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] bank;
        logic [13:0] addr;
    } cmd_pins_t;

    typedef struct packed {
        logic cke;
        logic term;
        logic x16;
        logic lo_strobe;
        logic hi_strobe;
        logic lo_mask;
        logic hi_mask;
    } misc_pins_t;

    typedef struct packed {
        cmd_kind_t kind;
        logic [2:0] bank;
        logic [13:0] addr;
    } cmd_t;

    typedef struct packed {
        logic valid;
        cmd_kind_t kind;
        logic [2:0] bank;
        logic [13:0] row_col;
        logic auto_pre;
        logic pre_all;
    } access_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
        logic [1:0] lane_keep;
    } wr_beat_t;

endpackage

// File: verilog/cmd_decode.sv
// command decoder: turns synchronised command pins into a command kind
// assumes its inputs are already on ref_clk (no further synchronising)
`timescale 1ns/1ps
`default_nettype none
`include "ddr_pin_params.svh"

module cmd_decode (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire ddr_pin_pkg::cmd_pins_t pins,
    input wire logic cke,
    input wire logic low_power,
    output var ddr_pin_pkg::cmd_t cmd_q,
    output logic cke_q
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic ddr_pin_pkg::cmd_kind_t decode(input logic [3:0] code);
        case (code)
            `CODE_MODE_SET: decode = ddr_pin_pkg::CMD_MODE;
            `CODE_REFRESH: decode = ddr_pin_pkg::CMD_REFRESH;
            `CODE_PRECHARGE: decode = ddr_pin_pkg::CMD_PRECHARGE;
            `CODE_ACTIVATE: decode = ddr_pin_pkg::CMD_ACTIVATE;
            `CODE_WRITE: decode = ddr_pin_pkg::CMD_WRITE;
            `CODE_READ: decode = ddr_pin_pkg::CMD_READ;
            default: decode = ddr_pin_pkg::CMD_NONE;
        endcase
    endfunction

    logic cmd_open;

    // previous-cycle clock gate must be high, as for a self refresh entry
    assign cmd_open = cke_q && !low_power && !pins.cs_n; // see R4, see R20

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= cke;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_q <= '0;
        end else begin
            // see R5
            cmd_q.kind <= cmd_open ?
                decode({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n}) :
                ddr_pin_pkg::CMD_NONE;
            cmd_q.bank <= pins.bank;
            cmd_q.addr <= pins.addr;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_cs_masks_cmd: assert property (pins.cs_n |=> cmd_q.kind == ddr_pin_pkg::CMD_NONE) // see R4
        else $error("command taken with chip select high");
    a_read_decode: assert property (cmd_open && pins.ras_n && !pins.cas_n && pins.we_n
        |=> cmd_q.kind == ddr_pin_pkg::CMD_READ) // see R5
        else $error("read code not decoded as read");
    a_gate_closed: assert property (!cke_q |=> cmd_q.kind == ddr_pin_pkg::CMD_NONE) // see R20
        else $error("command decoded with clock gate low");

endmodule
`default_nettype wire

// File: verilog/ddr_pin_if.sv
// pin-level command and data interface of a double-data-rate memory device
// assumes all pins are asynchronous to ref_clk; rd_valid and rd_data come
// from the array logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "ddr_pin_params.svh"

// Functional notes
// R1: controller keeps clock gate high during accesses
// R2: power-down ignores all but clock, termination, gate
// R3: self refresh observes only the clock gate
// R4: chip select high masks every command
// R5: commands decoded from strobes and chip select
// R6: termination enable applies termination to lanes
// R7: termination input ignored when disabled in register
// R8: masked write beats are discarded
// R9: x8 mask pin becomes read strobe when selected
// R10: bank select picks bank or mode register
// R11: address carries row, column, opcode
// R12: precharge flag selects one or all banks
// R13: read strobe edge-aligned, write strobe centred
// R14: low strobe low byte, high strobe high
// R15: register bit enables complementary strobes together
// R16: gate synchronous except self refresh exit
// R17: gate low enters power-down or self refresh
// R18: inputs sampled on rising clock edge
// R19: read strobe mirrors data strobe, masking off
// R20: decode only with gate high, select low
module ddr_pin_if (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire ddr_pin_pkg::cmd_pins_t cmd_pins,
    input wire logic clock_gate,
    input wire logic termination_enable,
    input wire logic org_x16,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    input wire logic low_byte_strobe_in,
    output logic low_byte_strobe_out,
    output logic low_byte_strobe_oe_n,
    input wire logic high_byte_strobe_in,
    output logic high_byte_strobe_out,
    output logic high_byte_strobe_oe_n,
    input wire logic low_byte_mask,
    output logic read_only_strobe_out,
    output logic read_only_strobe_oe_n,
    input wire logic high_byte_mask,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    output logic diff_strobe_on,
    output logic [1:0] term_on,
    output var ddr_pin_pkg::pwr_state_t pwr_state,
    output var ddr_pin_pkg::access_req_t access_req,
    output var ddr_pin_pkg::wr_beat_t wr_beat,
    output logic [13:0] mode_reg,
    output logic [13:0] ext_mode_reg_one
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    ddr_pin_pkg::cmd_pins_t cmd_s1_q, cmd_s2_q;
    ddr_pin_pkg::misc_pins_t misc_s1_q, misc_s2_q;
    logic [15:0] dq_s1_q, dq_s2_q;
    logic lo_s3_q, hi_s3_q;

    // see R18
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_s1_q <= '0;
            cmd_s2_q <= '0;
            misc_s1_q <= '0;
            misc_s2_q <= '0;
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
            lo_s3_q <= 1'b0;
            hi_s3_q <= 1'b0;
        end else begin
            cmd_s1_q <= cmd_pins;
            cmd_s2_q <= cmd_s1_q;
            misc_s1_q <= {clock_gate, termination_enable, org_x16, low_byte_strobe_in,
                          high_byte_strobe_in, low_byte_mask, high_byte_mask};
            misc_s2_q <= misc_s1_q;
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            lo_s3_q <= misc_s2_q.lo_strobe;
            hi_s3_q <= misc_s2_q.hi_strobe;
        end
    end

    // ----------------------------------------
    // command decode and power state
    // ----------------------------------------
    ddr_pin_pkg::cmd_t cmd_q;
    ddr_pin_pkg::pwr_state_t pwr_q;
    logic cke_q, cke_prev_q, low_power, inputs_live;
    logic [7:0] banks_q, banks_d;
    logic [13:0] mr_q, emr1_q;

    // power-down keeps clock, termination and gate; self refresh only the gate
    assign low_power = (pwr_q == ddr_pin_pkg::PWR_PRE_DOWN) ||
                       (pwr_q == ddr_pin_pkg::PWR_ACT_DOWN) ||
                       (pwr_q == ddr_pin_pkg::PWR_SELF_REF);
    assign inputs_live = !low_power; // see R2, see R3

    cmd_decode u_decode (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pins(cmd_s2_q),
        .cke(misc_s2_q.cke),
        .low_power(low_power),
        .cmd_q(cmd_q),
        .cke_q(cke_q)
    );

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= cke_q;
        end
    end

    always_comb begin
        banks_d = banks_q;
        case (cmd_q.kind)
            ddr_pin_pkg::CMD_ACTIVATE: banks_d[cmd_q.bank] = 1'b1; // see R10
            ddr_pin_pkg::CMD_PRECHARGE: begin
                if (cmd_q.addr[`BIT_PRECHARGE_ALL]) begin // see R12
                    banks_d = 8'h00;
                end else begin
                    banks_d[cmd_q.bank] = 1'b0;
                end
            end
            // auto-precharge closes the row; burst timing is the array's concern
            ddr_pin_pkg::CMD_READ, ddr_pin_pkg::CMD_WRITE: begin
                if (cmd_q.addr[`BIT_PRECHARGE_ALL]) begin
                    banks_d[cmd_q.bank] = 1'b0;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            banks_q <= 8'h00;
        end else begin
            banks_q <= banks_d;
        end
    end

    // see R1: no access is expected while the gate is low, so none is tracked
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pwr_q <= ddr_pin_pkg::PWR_IDLE;
        end else begin
            unique case (pwr_q)
                ddr_pin_pkg::PWR_IDLE, ddr_pin_pkg::PWR_ACTIVE: begin
                    if (cmd_q.kind == ddr_pin_pkg::CMD_REFRESH && !cke_q) begin
                        pwr_q <= ddr_pin_pkg::PWR_SELF_REF; // see R17
                    end else if (cke_prev_q && !cke_q) begin // see R16
                        pwr_q <= (banks_q == 8'h00) ? ddr_pin_pkg::PWR_PRE_DOWN :
                                 ddr_pin_pkg::PWR_ACT_DOWN; // see R17
                    end else begin
                        pwr_q <= (banks_d != 8'h00) ? ddr_pin_pkg::PWR_ACTIVE :
                                 ddr_pin_pkg::PWR_IDLE;
                    end
                end
                ddr_pin_pkg::PWR_PRE_DOWN: begin
                    if (cke_q) begin
                        pwr_q <= ddr_pin_pkg::PWR_IDLE;
                    end
                end
                ddr_pin_pkg::PWR_ACT_DOWN: begin
                    if (cke_q) begin
                        pwr_q <= ddr_pin_pkg::PWR_ACTIVE;
                    end
                end
                // exit does not wait for the command pipeline
                ddr_pin_pkg::PWR_SELF_REF: begin
                    if (misc_s2_q.cke) begin // see R16
                        pwr_q <= ddr_pin_pkg::PWR_IDLE;
                    end
                end
                default: pwr_q <= ddr_pin_pkg::PWR_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // mode registers and access requests
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mr_q <= `MR_RESET;
            emr1_q <= `EMR1_RESET;
        end else if (cmd_q.kind == ddr_pin_pkg::CMD_MODE) begin
            if (cmd_q.bank == `SEL_MODE_REG) begin // see R10
                mr_q <= cmd_q.addr; // see R11
            end else if (cmd_q.bank == `SEL_EXT_REG_ONE) begin
                emr1_q <= cmd_q.addr;
            end
        end
    end

    ddr_pin_pkg::access_req_t req_q;
    logic is_rw;

    assign is_rw = (cmd_q.kind == ddr_pin_pkg::CMD_READ) ||
                   (cmd_q.kind == ddr_pin_pkg::CMD_WRITE);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_q <= '0;
        end else begin
            req_q.valid <= (cmd_q.kind != ddr_pin_pkg::CMD_NONE) &&
                           (cmd_q.kind != ddr_pin_pkg::CMD_REFRESH);
            req_q.kind <= cmd_q.kind;
            req_q.bank <= cmd_q.bank; // see R10
            req_q.row_col <= cmd_q.addr; // see R11
            req_q.auto_pre <= is_rw && cmd_q.addr[`BIT_PRECHARGE_ALL];
            req_q.pre_all <= (cmd_q.kind == ddr_pin_pkg::CMD_PRECHARGE) &&
                             cmd_q.addr[`BIT_PRECHARGE_ALL]; // see R12
        end
    end

    // ----------------------------------------
    // termination and strobe options
    // ----------------------------------------
    logic term_allowed, ros_on;
    logic [1:0] term_q;
    logic diff_q;

    assign term_allowed = emr1_q[`BIT_TERM_LO] || emr1_q[`BIT_TERM_HI]; // see R7
    assign ros_on = !misc_s2_q.x16 && emr1_q[`BIT_READ_STROBE_EN]; // see R9

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            term_q <= 2'h0;
            diff_q <= 1'b1;
        end else begin
            // termination stays usable in power-down, never in self refresh
            term_q[0] <= misc_s2_q.term && term_allowed &&
                         (pwr_q != ddr_pin_pkg::PWR_SELF_REF); // see R6, see R3
            term_q[1] <= misc_s2_q.term && term_allowed && misc_s2_q.x16 &&
                         (pwr_q != ddr_pin_pkg::PWR_SELF_REF); // see R6
            diff_q <= !emr1_q[`BIT_STROBE_DIFF_OFF]; // see R15
        end
    end

    // ----------------------------------------
    // write beats
    // ----------------------------------------
    function automatic logic [3:0] beats_of(input logic [13:0] mr);
        beats_of = (mr[`MR_BL_MSB:`MR_BL_LSB] == `BL_EIGHT) ? `BEATS_EIGHT : `BEATS_FOUR;
    endfunction

    logic lo_edge, hi_edge, take_beat;
    logic [3:0] wr_left_q;
    ddr_pin_pkg::wr_beat_t beat_q;

    // both strobe edges carry a beat; the controller centres them in the data
    assign lo_edge = misc_s2_q.lo_strobe ^ lo_s3_q; // see R13
    assign hi_edge = misc_s2_q.hi_strobe ^ hi_s3_q;
    assign take_beat = lo_edge && (wr_left_q != 4'h0) && inputs_live; // see R2

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_left_q <= 4'h0;
        end else if (cmd_q.kind == ddr_pin_pkg::CMD_WRITE) begin
            wr_left_q <= beats_of(mr_q);
        end else if (take_beat) begin
            wr_left_q <= wr_left_q - 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            beat_q <= '0;
        end else begin
            beat_q.valid <= take_beat;
            beat_q.data <= dq_s2_q;
            // masking is off while the mask pin serves as read strobe
            beat_q.lane_keep[0] <= ros_on || !misc_s2_q.lo_mask; // see R8, see R19
            beat_q.lane_keep[1] <= misc_s2_q.x16 && hi_edge &&
                                   !misc_s2_q.hi_mask; // see R14, see R8
        end
    end

    // ----------------------------------------
    // read drive
    // ----------------------------------------
    logic [15:0] dq_q;
    logic dq_oe_n_q, lo_str_q, lo_oe_n_q, hi_str_q, hi_oe_n_q, ros_q, ros_oe_n_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dq_q <= 16'h0000;
            dq_oe_n_q <= 1'b1;
            lo_str_q <= 1'b0;
            lo_oe_n_q <= 1'b1;
            hi_str_q <= 1'b0;
            hi_oe_n_q <= 1'b1;
            ros_q <= 1'b0;
            ros_oe_n_q <= 1'b1;
        end else begin
            // data and strobe change on the same edge: edge-aligned
            dq_q <= rd_data;
            dq_oe_n_q <= !rd_valid;
            lo_str_q <= rd_valid && !lo_str_q; // see R13, see R14
            lo_oe_n_q <= !rd_valid;
            hi_str_q <= rd_valid && misc_s2_q.x16 && !hi_str_q; // see R14
            hi_oe_n_q <= !(rd_valid && misc_s2_q.x16);
            ros_q <= rd_valid && ros_on && !lo_str_q; // see R19
            ros_oe_n_q <= !(rd_valid && ros_on); // see R9
        end
    end

    assign dq_out = dq_q;
    assign dq_oe_n = dq_oe_n_q;
    assign low_byte_strobe_out = lo_str_q;
    assign low_byte_strobe_oe_n = lo_oe_n_q;
    assign high_byte_strobe_out = hi_str_q;
    assign high_byte_strobe_oe_n = hi_oe_n_q;
    assign read_only_strobe_out = ros_q;
    assign read_only_strobe_oe_n = ros_oe_n_q;
    assign diff_strobe_on = diff_q;
    assign term_on = term_q;
    assign pwr_state = pwr_q;
    assign access_req = req_q;
    assign wr_beat = beat_q;
    assign mode_reg = mr_q;
    assign ext_mode_reg_one = emr1_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_pd_no_beats: assert property (low_power |=> !beat_q.valid) // see R2
        else $error("write beat taken in low power");
    a_sr_term_off: assert property (pwr_q == ddr_pin_pkg::PWR_SELF_REF |=> term_q == 2'h0) // see R3
        else $error("termination on in self refresh");
    a_term_follows: assert property (misc_s2_q.term && term_allowed &&
        pwr_q != ddr_pin_pkg::PWR_SELF_REF |=> term_q[0]) // see R6
        else $error("termination not applied");
    a_term_ignored: assert property (!term_allowed |=> term_q == 2'h0) // see R7
        else $error("termination input not ignored");
    a_mask_drops: assert property (take_beat && misc_s2_q.lo_mask && !ros_on
        |=> beat_q.valid && !beat_q.lane_keep[0]) // see R8
        else $error("masked beat kept");
    a_ros_mirror: assert property (!ros_oe_n_q |-> ros_q == lo_str_q && !lo_oe_n_q) // see R19
        else $error("read strobe differs from data strobe");
    a_act_bank: assert property (cmd_q.kind == ddr_pin_pkg::CMD_ACTIVATE
        |=> req_q.valid && req_q.bank == $past(cmd_q.bank) && banks_q[req_q.bank]) // see R10
        else $error("activate bank not taken");
    a_pre_all: assert property (cmd_q.kind == ddr_pin_pkg::CMD_PRECHARGE &&
        cmd_q.addr[`BIT_PRECHARGE_ALL] |=> banks_q == 8'h00 && req_q.pre_all) // see R12
        else $error("precharge all left a bank open");
    a_diff_strobe: assert property (##1 diff_q == !$past(emr1_q[`BIT_STROBE_DIFF_OFF])) // see R15
        else $error("strobe pairing not following register");
    a_sr_entry: assert property (pwr_q == ddr_pin_pkg::PWR_IDLE &&
        cmd_q.kind == ddr_pin_pkg::CMD_REFRESH && !cke_q
        |=> pwr_q == ddr_pin_pkg::PWR_SELF_REF ##1 !u_decode.cmd_open) // see R17
        else $error("self refresh not entered");
    a_pd_kind: assert property (cke_prev_q && !cke_q && cmd_q.kind == ddr_pin_pkg::CMD_NONE &&
        pwr_q == ddr_pin_pkg::PWR_ACTIVE |=> pwr_q == ddr_pin_pkg::PWR_ACT_DOWN) // see R17
        else $error("active power-down not entered");
    a_read_edge: assert property (rd_valid |=> !dq_oe_n_q && lo_str_q != $past(lo_str_q)) // see R13
        else $error("read strobe not toggled with data");

    c_write_beat: cover property (beat_q.valid && beat_q.lane_keep == 2'h3);
    c_self_ref: cover property (pwr_q == ddr_pin_pkg::PWR_SELF_REF ##1
        pwr_q == ddr_pin_pkg::PWR_IDLE);
    c_pre_all: cover property (req_q.valid && req_q.pre_all);
    c_read_strobe: cover property (!ros_oe_n_q);

endmodule
`default_nettype wire

// File: testbench/ctrl_model.sv
// controller model: drives command pins, clock gate and write bursts
// assumes tasks are called from one bench process after reset release
`timescale 1ns/1ps
`default_nettype none
// ----
// model
// ----
module ctrl_model (
    input wire logic ref_clk,
    output var ddr_pin_pkg::cmd_pins_t cmd_pins,
    output logic clock_gate,
    output logic [15:0] dq_in,
    output logic low_byte_strobe_in,
    output logic high_byte_strobe_in,
    output logic low_byte_mask,
    output logic high_byte_mask
);
    initial begin
        cmd_pins = '1;
        clock_gate = 1'b1;
        dq_in = 16'h0000;
        low_byte_strobe_in = 1'b0;
        high_byte_strobe_in = 1'b0;
        low_byte_mask = 1'b0;
        high_byte_mask = 1'b0;
    end
    // one command cycle, then deselect with the inverse pattern so stale pins never match
    task automatic cmd(input logic [3:0] code, input logic [2:0] bank, input logic [13:0] addr,
            input logic gate);
        @(posedge ref_clk);
        cmd_pins <= {code, bank, addr};
        clock_gate <= gate;
        @(posedge ref_clk);
        cmd_pins <= {1'b1, ~code[2:0], ~bank, ~addr};
    endtask
    task automatic burst(input int n, input int masked);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            dq_in <= 16'h1100 + 16'(i);
            low_byte_mask <= (i == masked);
            high_byte_mask <= (i == masked + 1);
            @(negedge ref_clk); // centred in the beat
            low_byte_strobe_in <= ~low_byte_strobe_in;
            high_byte_strobe_in <= ~high_byte_strobe_in;
        end
        @(posedge ref_clk);
        dq_in <= ~dq_in;
        low_byte_mask <= 1'b0;
        high_byte_mask <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: testbench/ddr_pin_if_test.sv
// bench for the pin interface: command, write, read, termination, power
// assumes x16 strap until the final x8 read-strobe check, and the controller model on the far side
`timescale 1ns/1ps
`default_nettype none
`include "ddr_pin_params.svh"
// ----
// bench
// ----
module ddr_pin_if_test;
    logic ref_clk, resetn, clock_gate, termination_enable, org_x16, rd_valid;
    logic low_byte_strobe_in, low_byte_strobe_out, low_byte_strobe_oe_n;
    logic high_byte_strobe_in, high_byte_strobe_out, high_byte_strobe_oe_n;
    logic low_byte_mask, high_byte_mask, read_only_strobe_out, read_only_strobe_oe_n;
    logic dq_oe_n, diff_strobe_on;
    logic [15:0] dq_in, dq_out, rd_data;
    logic [1:0] term_on;
    logic [13:0] mode_reg, ext_mode_reg_one;
    ddr_pin_pkg::cmd_pins_t cmd_pins;
    ddr_pin_pkg::pwr_state_t pwr_state;
    ddr_pin_pkg::access_req_t access_req;
    ddr_pin_pkg::wr_beat_t wr_beat;
    int err_total = 0;
    int checks_done = 0;
    int beats = 0;
    ddr_pin_if uut (.*);
    ctrl_model m (.*);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait; a refused command must leave the request idle
    task automatic req(input ddr_pin_pkg::cmd_kind_t kind, input logic [2:0] bank,
            input logic [1:0] flags);
        int n;
        n = 0;
        while (access_req.valid !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("request", {8'h00, kind, bank, flags}, access_req.valid !== 1'b1 ? 16'h0000 :
            {8'h00, access_req.kind, access_req.bank, access_req.auto_pre, access_req.pre_all});
    endtask
    always @(posedge ref_clk) begin
        #1;
        if (wr_beat.valid === 1'b1) begin
            chk("beat data", 16'h1100 + 16'(beats), wr_beat.data);
            chk("beat keep", {14'h0, beats != 3, beats != 2}, 16'(wr_beat.lane_keep));
            beats++;
        end
    end
    task automatic conclude();
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        conclude();
    end
    initial begin
        resetn = 1'b0;
        termination_enable = 1'b0;
        org_x16 = 1'b1;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("dq oe_n", 16'h1, 16'(dq_oe_n));
        chk("power state", 16'(ddr_pin_pkg::PWR_IDLE), 16'(pwr_state));
        m.cmd(`CODE_MODE_SET, `SEL_MODE_REG, 14'h0003, 1'b1);
        req(ddr_pin_pkg::CMD_MODE, 3'h0, 2'b00);
        m.cmd(`CODE_MODE_SET, `SEL_EXT_REG_ONE, 14'h0404, 1'b1);
        req(ddr_pin_pkg::CMD_MODE, 3'h1, 2'b00);
        @(posedge ref_clk);
        #1;
        chk("mode reg", 16'h0003, 16'(mode_reg));
        chk("ext mode", 16'h0404, 16'(ext_mode_reg_one));
        chk("diff strobes", 16'h0, 16'(diff_strobe_on));
        m.cmd(`CODE_ACTIVATE | 4'h8, 3'h2, 14'h0123, 1'b1);
        req(ddr_pin_pkg::CMD_NONE, 3'h0, 2'b00);
        m.cmd(`CODE_ACTIVATE, 3'h2, 14'h0123, 1'b1);
        req(ddr_pin_pkg::CMD_ACTIVATE, 3'h2, 2'b00);
        chk("row", 16'h0123, 16'(access_req.row_col));
        chk("power state", 16'(ddr_pin_pkg::PWR_ACTIVE), 16'(pwr_state));
        m.cmd(`CODE_WRITE, 3'h2, 14'h0400, 1'b1);
        req(ddr_pin_pkg::CMD_WRITE, 3'h2, 2'b10);
        m.burst(9, 2);
        repeat (6) @(posedge ref_clk);
        chk("beat count", 16'h8, 16'(beats));
        rd_valid <= 1'b1;
        rd_data <= 16'ha55a;
        @(posedge ref_clk);
        rd_data <= 16'h3cc3;
        #1;
        chk("read data", 16'ha55a, dq_out);
        chk("read strobes", 16'h000a, {7'h0, dq_oe_n, 4'h0, high_byte_strobe_out,
            high_byte_strobe_oe_n, low_byte_strobe_out, low_byte_strobe_oe_n});
        @(posedge ref_clk);
        rd_valid <= 1'b0;
        #1;
        chk("read data", 16'h3cc3, dq_out);
        chk("low strobe", 16'h0, 16'(low_byte_strobe_out));
        @(posedge ref_clk);
        #1;
        chk("dq oe_n", 16'h1, 16'(dq_oe_n));
        termination_enable <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("termination", 16'h3, 16'(term_on));
        m.cmd(`CODE_MODE_SET, `SEL_EXT_REG_ONE, 14'h0000, 1'b1);
        req(ddr_pin_pkg::CMD_MODE, 3'h1, 2'b00);
        repeat (5) @(posedge ref_clk);
        chk("termination", 16'h0, 16'(term_on));
        chk("diff strobes", 16'h1, 16'(diff_strobe_on));
        m.cmd(`CODE_PRECHARGE, 3'h5, 14'h0400, 1'b1);
        req(ddr_pin_pkg::CMD_PRECHARGE, 3'h5, 2'b01);
        m.cmd(4'hf, 3'h0, 14'h0000, 1'b0);
        repeat (6) @(posedge ref_clk);
        chk("power state", 16'(ddr_pin_pkg::PWR_PRE_DOWN), 16'(pwr_state));
        m.cmd(`CODE_ACTIVATE, 3'h1, 14'h0000, 1'b0);
        req(ddr_pin_pkg::CMD_NONE, 3'h0, 2'b00);
        m.cmd(4'hf, 3'h0, 14'h0000, 1'b1);
        repeat (6) @(posedge ref_clk);
        m.cmd(`CODE_REFRESH, 3'h0, 14'h0000, 1'b0);
        repeat (6) @(posedge ref_clk);
        chk("power state", 16'(ddr_pin_pkg::PWR_SELF_REF), 16'(pwr_state));
        m.cmd(4'hf, 3'h0, 14'h0000, 1'b1);
        repeat (3) @(posedge ref_clk);
        chk("power state", 16'(ddr_pin_pkg::PWR_IDLE), 16'(pwr_state));
        org_x16 <= 1'b0;
        m.cmd(`CODE_MODE_SET, `SEL_EXT_REG_ONE, 14'h0800, 1'b1);
        req(ddr_pin_pkg::CMD_MODE, 3'h1, 2'b00);
        @(posedge ref_clk);
        rd_valid <= 1'b1;
        @(posedge ref_clk);
        rd_valid <= 1'b0;
        #1;
        chk("x8 strobes", 16'h5, {13'h0, high_byte_strobe_oe_n, read_only_strobe_oe_n,
            read_only_strobe_out});
        conclude();
    end
endmodule
`default_nettype wire
